/* File: design/can_wake_map.svh */
// Register offsets, write masks, reset values and timing for the CAN wake block
`ifndef CAN_WAKE_MAP_SVH
`define CAN_WAKE_MAP_SVH

`define PN_BITRATE_OFS 8'h26
`define PN_IDENT0_OFS 8'h27
`define PN_IDENT1_OFS 8'h28
`define PN_IDENT2_OFS 8'h29
`define PN_IDENT3_OFS 8'h2a
`define PN_MASK0_OFS 8'h2b
`define PN_MASK1_OFS 8'h2c
`define PN_MASK2_OFS 8'h2d
`define PN_MASK3_OFS 8'h2e

`define PN_BITRATE_RESET 8'h05
`define PN_IDENT_RESET 8'h00
`define PN_MASK_RESET 8'h00

`define PN_BITRATE_WMASK 8'h07
`define PN_BYTE3_WMASK 8'h1f
`define PN_FULL_WMASK 8'hff

`define CLK_PERIOD_NS 25
`define PHASE_FILTER_TIME_NS 1000
`define PATTERN_WINDOW_TIME_NS 1000000
`define PHASE_FILTER_CYCLES ((`PHASE_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PATTERN_WINDOW_CYCLES (`PATTERN_WINDOW_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: design/can_wake_pkg.sv */
// Types shared by the CAN wake pattern and identifier filter block
package can_wake_pkg;

  typedef enum logic [2:0] {
    RATE_50 = 3'h0,
    RATE_100 = 3'h1,
    RATE_125 = 3'h2,
    RATE_250 = 3'h3,
    RATE_500 = 3'h5,
    RATE_1000 = 3'h7
  } pn_rate_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST_DOM = 3'b010,
    ST_GAP_REC = 3'b100
  } wake_state_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic len_ok;
    logic target_ro;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] mode;
  } spi_cmd_t;

  typedef struct packed {
    logic extended;
    logic [28:0] ident;
    logic [28:0] mask;
  } frame_filter_t;

endpackage

/* File: design/can_wake_pattern_filter.sv */
// CAN wake pattern detector, host command wake and partial networking config registers
`include "can_wake_map.svh"

module can_wake_pattern_filter
  import can_wake_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = `PHASE_FILTER_CYCLES,
  parameter int unsigned WINDOW_CYCLES = `PATTERN_WINDOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  // Bus comparator, dominant high, asynchronous
  input wire logic bus_dominant,
  // Mode and control bits kept elsewhere
  input wire logic transceiver_lowpower_standby,
  input wire logic sleep_mode,
  input wire logic bus_wake_enable,
  input wire logic selective_wake_enable,
  input wire logic extended_format_select,
  input wire logic cfg_confirm_set,
  input wire logic other_pn_cfg_write,
  input wire logic bus_wake_status_clear,
  input wire logic wake_frame_valid,
  // Host command side
  input wire logic lowpower_mode,
  input wire logic logic_supply_on,
  input wire logic spi_enabled,
  input wire spi_cmd_t cmd,
  output logic [7:0] reg_rdata,
  output logic spi_wake,
  output logic [2:0] spi_wake_mode,
  output logic cmd_fault_event,
  // Wake results
  output logic bus_wake_status,
  output logic rxd_force_low,
  output logic bias_on,
  output logic standby_request,
  output logic selective_cfg_confirmed,
  output pn_rate_t bitrate_select_field,
  output frame_filter_t frame_filter
);

  localparam logic [19:0] FILTER_LIM = 20'(FILTER_CYCLES - 1);
  localparam logic [19:0] WINDOW_LIM = 20'(WINDOW_CYCLES - 1);
  localparam int unsigned NUM_REGS = 9;

  // Rate decode; reserved codes fall to 500
  function automatic pn_rate_t rate_decode(input logic [2:0] code);
    pn_rate_t r;
    unique case (code)
      3'h0: r = RATE_50;
      3'h1: r = RATE_100;
      3'h2: r = RATE_125;
      3'h3: r = RATE_250;
      3'h7: r = RATE_1000;
      default: r = RATE_500;
    endcase
    return r;
  endfunction

  // Assemble a 29-bit comparison word from four bytes
  function automatic logic [28:0] ident_build(
    input logic ext,
    input logic [7:0] b0,
    input logic [7:0] b1,
    input logic [7:0] b2,
    input logic [7:0] b3,
    input logic fill
  );
    logic [28:0] w;
    if (ext) begin
      w = {b3[4:0], b2[7:2], b2[1:0], b1, b0};
    end else begin
      w = {{18{fill}}, b3[4:0], b2[7:2]};
    end
    return w;
  endfunction

  // Writable bits per register index
  function automatic logic [7:0] write_mask(input logic [3:0] idx);
    logic [7:0] m;
    unique case (idx)
      4'h0: m = `PN_BITRATE_WMASK;
      4'h4: m = `PN_BYTE3_WMASK;
      4'h8: m = `PN_BYTE3_WMASK;
      default: m = `PN_FULL_WMASK;
    endcase
    return m;
  endfunction

  // Register array, index 0 is the rate register
  logic [7:0] pn_reg [0:NUM_REGS-1];

  // Address decode of the host command
  wire logic [7:0] addr_diff;
  wire logic [3:0] reg_idx;
  wire logic reg_hit;
  wire logic cmd_ok;
  wire logic cmd_bad;
  wire logic reg_wr;
  wire logic reg_rd;
  assign addr_diff = cmd.addr - `PN_BITRATE_OFS;
  assign reg_idx = addr_diff[3:0];
  assign reg_hit = (cmd.addr >= `PN_BITRATE_OFS) && (cmd.addr <= `PN_MASK3_OFS);
  assign cmd_bad = cmd.sel & (~cmd.len_ok | (cmd.write & cmd.target_ro));
  assign cmd_ok = cmd.sel & ~cmd_bad;
  assign reg_wr = cmd_ok & cmd.write & reg_hit;
  assign reg_rd = cmd_ok & ~cmd.write & reg_hit;

  // Host command wake qualification
  // Any non-faulty command wakes in low-power mode with logic supply and SPI on, whatever address it carries
  wire logic cmd_wake;
  assign cmd_wake = cmd_ok & lowpower_mode & logic_supply_on & spi_enabled;

  // Reserved bits never stored, so they read back zero
  // Writes to unmapped offsets are dropped without a fault
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pn_reg[0] <= `PN_BITRATE_RESET;
      for (int i = 1; i < 5; i++) begin
        pn_reg[i] <= `PN_IDENT_RESET;
      end
      for (int i = 5; i < NUM_REGS; i++) begin
        pn_reg[i] <= `PN_MASK_RESET;
      end
    end else if (reg_wr) begin
      pn_reg[reg_idx] <= cmd.wdata & write_mask(reg_idx);
    end
  end

  // Read data registered; misses answer zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (cmd.sel) begin
      reg_rdata <= reg_rd ? pn_reg[reg_idx] : 8'h00;
    end
  end

  // Command wake and fault pulses
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spi_wake <= 1'b0;
      spi_wake_mode <= 3'h0;
      cmd_fault_event <= 1'b0;
    end else begin
      spi_wake <= cmd_wake;
      cmd_fault_event <= cmd_bad;
      if (cmd_wake) begin
        spi_wake_mode <= cmd.mode;
      end
    end
  end

  // Confirmed flag; a set in the same cycle as a write wins
  wire logic cfg_write;
  logic next_cfg_confirmed;
  assign cfg_write = reg_wr | other_pn_cfg_write;
  always_comb begin
    next_cfg_confirmed = selective_cfg_confirmed;
    if (cfg_write) begin
      next_cfg_confirmed = 1'b0;
    end
    if (cfg_confirm_set) begin
      next_cfg_confirmed = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      selective_cfg_confirmed <= 1'b0;
    end else begin
      selective_cfg_confirmed <= next_cfg_confirmed;
    end
  end

  // Rate decode registered so the matcher never sees a half-written code
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitrate_select_field <= RATE_500;
    end else begin
      bitrate_select_field <= rate_decode(pn_reg[0][2:0]);
    end
  end

  // Decoded views for the frame matcher, registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_filter <= '0;
    end else begin
      frame_filter.extended <= extended_format_select;
      frame_filter.ident <= ident_build(extended_format_select,
        pn_reg[1], pn_reg[2], pn_reg[3], pn_reg[4], 1'b0);
      // Unused upper bits of a standard mask are don't-care
      frame_filter.mask <= ident_build(extended_format_select,
        pn_reg[5], pn_reg[6], pn_reg[7], pn_reg[8], 1'b1);
    end
  end

  // Two-stage synchroniser on the bus comparator
  // Both stages reset recessive, so release shows no false edge
  logic bus_meta;
  logic bus_sync;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_meta <= 1'b0;
      bus_sync <= 1'b0;
    end else begin
      bus_meta <= bus_dominant;
      bus_sync <= bus_meta;
    end
  end

  // Level filter: a level counts only after it stands a full filter time
  logic bus_filt;
  logic [19:0] filt_cnt;
  wire logic filt_differs;
  wire logic filt_flip;
  wire logic dom_start;
  wire logic rec_start;
  assign filt_differs = bus_sync != bus_filt;
  assign filt_flip = filt_differs && (filt_cnt == FILTER_LIM);
  assign dom_start = filt_flip & bus_sync;
  assign rec_start = filt_flip & ~bus_sync;

  // Any short interval restarts the count, so it is never seen
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_filt <= 1'b0;
      filt_cnt <= 20'h00000;
    end else if (!filt_differs || filt_flip) begin
      filt_cnt <= 20'h00000;
      if (filt_flip) begin
        bus_filt <= bus_sync;
      end
    end else begin
      filt_cnt <= filt_cnt + 20'h00001;
    end
  end

  // Detector runs only in low-power standby with bus wake on
  wire logic monitor;
  wire logic plain_wake;
  assign monitor = transceiver_lowpower_standby & bus_wake_enable;
  assign plain_wake = ~selective_wake_enable | ~selective_cfg_confirmed;

  // Pattern state machine and window timer
  wake_state_t state;
  wake_state_t next_state;
  logic [19:0] win_cnt;
  logic pattern_hit;
  wire logic win_expired;
  // Expiry beats a hit that falls in the same cycle
  assign win_expired = win_cnt == WINDOW_LIM;

  // A clamped bus never restarts: a fresh dominant edge is needed
  // Any code that is not one-hot falls back to idle
  always_comb begin
    next_state = state;
    pattern_hit = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (monitor && dom_start) begin
          next_state = ST_FIRST_DOM;
        end
      end
      ST_FIRST_DOM: begin
        if (!monitor || win_expired) begin
          next_state = ST_IDLE;
        end else if (rec_start) begin
          next_state = ST_GAP_REC;
        end
      end
      ST_GAP_REC: begin
        if (!monitor || win_expired) begin
          next_state = ST_IDLE;
        end else if (dom_start) begin
          next_state = ST_IDLE;
          pattern_hit = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Window counts from the first qualified dominant level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      win_cnt <= 20'h00000;
    end else if (next_state == ST_IDLE || state == ST_IDLE) begin
      win_cnt <= 20'h00000;
    end else begin
      win_cnt <= win_cnt + 20'h00001;
    end
  end

  // Wake outcomes
  wire logic wake_plain;
  wire logic wake_bias;
  wire logic wake_frame;
  assign wake_plain = pattern_hit & plain_wake;
  assign wake_bias = pattern_hit & ~plain_wake;
  assign wake_frame = bias_on & wake_frame_valid & bus_wake_enable;

  // Bias drops when the transceiver leaves low-power standby or bus wake is disabled
  // Limitation: a frame wake leaves bias on until then
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bias_on <= 1'b0;
    end else if (wake_bias) begin
      bias_on <= 1'b1;
    end else if (!transceiver_lowpower_standby || !bus_wake_enable) begin
      bias_on <= 1'b0;
    end
  end

  // Sticky status; a new wake beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_wake_status <= 1'b0;
    end else if (wake_plain || wake_frame) begin
      bus_wake_status <= 1'b1;
    end else if (bus_wake_status_clear) begin
      bus_wake_status <= 1'b0;
    end
  end

  // Receive pin held low while the wake is pending
  assign rxd_force_low = bus_wake_status;

  // One-cycle request to leave Sleep for Standby
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_request <= 1'b0;
    end else begin
      standby_request <= sleep_mode & (wake_plain | wake_frame);
    end
  end

endmodule

/* File: test/can_wake_asserts.sv */
// Port checker for the CAN wake pattern and filter block
module can_wake_asserts
  import can_wake_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sleep_mode,
  input wire logic bus_wake_enable,
  input wire logic selective_wake_enable,
  input wire logic cfg_confirm_set,
  input wire logic lowpower_mode,
  input wire logic logic_supply_on,
  input wire logic spi_enabled,
  input wire spi_cmd_t cmd,
  input wire logic [7:0] reg_rdata,
  input wire logic spi_wake,
  input wire logic [2:0] spi_wake_mode,
  input wire logic cmd_fault_event,
  input wire logic bus_wake_status,
  input wire logic rxd_force_low,
  input wire logic bias_on,
  input wire logic standby_request,
  input wire logic selective_cfg_confirmed,
  input wire pn_rate_t bitrate_select_field
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Command classes; a refused command must never wake
  wire bad = cmd.sel && (!cmd.len_ok || (cmd.write && cmd.target_ro));
  wire good = cmd.sel && !bad;
  wire pn_wr = good && cmd.write && cmd.addr >= 8'h26 && cmd.addr <= 8'h2e;
  wire hi_rd = good && !cmd.write && (cmd.addr == 8'h2a || cmd.addr == 8'h2e);
  property p_rxd_low;
    rxd_force_low == bus_wake_status;
  endproperty
  a_rxd_low: assert property (p_rxd_low) else $error("rxd not tied");
  property p_need_enable;
    $rose(bus_wake_status) |-> $past(bus_wake_enable);
  endproperty
  a_need_enable: assert property (p_need_enable) else $error("wake while off");
  property p_plain_standby;
    $rose(bus_wake_status) && $past(sleep_mode) && !$past(selective_wake_enable)
      |-> standby_request;
  endproperty
  a_plain_standby: assert property (p_plain_standby) else $error("no standby");
  property p_bias_first;
    $rose(bias_on) |-> !standby_request;
  endproperty
  a_bias_first: assert property (p_bias_first) else $error("standby early");
  property p_cmd_wake;
    good && lowpower_mode && logic_supply_on && spi_enabled
      |=> spi_wake && spi_wake_mode == $past(cmd.mode);
  endproperty
  a_cmd_wake: assert property (p_cmd_wake) else $error("no cmd wake");
  property p_fault;
    bad |=> cmd_fault_event && !spi_wake;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_rate_res;
    bitrate_select_field != 3'h4 && bitrate_select_field != 3'h6;
  endproperty
  a_rate_res: assert property (p_rate_res) else $error("reserved rate");
  property p_reserved;
    hi_rd |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits");
  property p_cfg_clear;
    pn_wr && !cfg_confirm_set |=> !selective_cfg_confirmed;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("confirm kept");
endmodule

bind can_wake_pattern_filter can_wake_asserts can_wake_asserts_inst (.core_clk(core_clk),
  .nrst(nrst), .sleep_mode(sleep_mode), .bus_wake_enable(bus_wake_enable),
  .selective_wake_enable(selective_wake_enable), .cfg_confirm_set(cfg_confirm_set),
  .lowpower_mode(lowpower_mode), .logic_supply_on(logic_supply_on), .spi_enabled(spi_enabled),
  .cmd(cmd), .reg_rdata(reg_rdata), .spi_wake(spi_wake), .spi_wake_mode(spi_wake_mode),
  .cmd_fault_event(cmd_fault_event), .bus_wake_status(bus_wake_status),
  .rxd_force_low(rxd_force_low), .bias_on(bias_on), .standby_request(standby_request),
  .selective_cfg_confirmed(selective_cfg_confirmed), .bitrate_select_field(bitrate_select_field));

/* File: test/can_bus_node.sv */
// Far-side CAN node driving the bus level in timed phases
module can_bus_node (
  input wire logic core_clk,
  output logic bus_dominant
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus is recessive, as the bus bias pulls it
  initial bus_dominant = 1'b0;
  // Level held n cycles, changed just after an edge
  task automatic drive(input logic lvl, input int n);
    @(posedge core_clk);
    bus_dominant <= lvl;
    repeat (n - 1) @(posedge core_clk);
    #1;
  endtask
  // Dominant, recessive, dominant, then recessive rest
  task automatic pattern(input int d1, input int r, input int d2);
    drive(1'b1, d1);
    drive(1'b0, r);
    drive(1'b1, d2);
    drive(1'b0, 6);
  endtask
endmodule

/* File: test/can_wake_pattern_filter_tb.sv */
// Self-checking bench of the CAN wake pattern and filter block
module can_wake_pattern_filter_tb
  import can_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, bus_dominant;
  logic transceiver_lowpower_standby = 1'b1, sleep_mode = 1'b1, bus_wake_enable = 1'b1;
  logic selective_wake_enable = 1'b0, extended_format_select = 1'b1, cfg_confirm_set = 1'b0;
  logic other_pn_cfg_write = 1'b0, bus_wake_status_clear = 1'b0, wake_frame_valid = 1'b0;
  logic lowpower_mode = 1'b1, logic_supply_on = 1'b1, spi_enabled = 1'b1;
  spi_cmd_t cmd = '0;
  logic [7:0] reg_rdata;
  logic [2:0] spi_wake_mode;
  logic spi_wake, cmd_fault_event, bus_wake_status, rxd_force_low;
  logic bias_on, standby_request, selective_cfg_confirmed;
  pn_rate_t bitrate_select_field;
  frame_filter_t frame_filter;
  int fails = 0;
  int tests_run = 0;
  // Short counts keep patterns and window expiry quick to run
  can_wake_pattern_filter #(.FILTER_CYCLES(4), .WINDOW_CYCLES(200)) can_wake_pattern_filter_inst (
    .core_clk(core_clk), .nrst(nrst), .bus_dominant(bus_dominant),
    .transceiver_lowpower_standby(transceiver_lowpower_standby), .sleep_mode(sleep_mode),
    .bus_wake_enable(bus_wake_enable), .selective_wake_enable(selective_wake_enable),
    .extended_format_select(extended_format_select), .cfg_confirm_set(cfg_confirm_set),
    .other_pn_cfg_write(other_pn_cfg_write), .bus_wake_status_clear(bus_wake_status_clear),
    .wake_frame_valid(wake_frame_valid), .lowpower_mode(lowpower_mode),
    .logic_supply_on(logic_supply_on), .spi_enabled(spi_enabled), .cmd(cmd),
    .reg_rdata(reg_rdata), .spi_wake(spi_wake), .spi_wake_mode(spi_wake_mode),
    .cmd_fault_event(cmd_fault_event), .bus_wake_status(bus_wake_status),
    .rxd_force_low(rxd_force_low), .bias_on(bias_on), .standby_request(standby_request),
    .selective_cfg_confirmed(selective_cfg_confirmed),
    .bitrate_select_field(bitrate_select_field), .frame_filter(frame_filter));
  can_bus_node can_bus_node_inst (.core_clk(core_clk), .bus_dominant(bus_dominant));
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // One command; answer and pulses are sampled just after the taking edge
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic ok,
                    input logic ro, input logic [2:0] m = 3'h2);
    @(posedge core_clk);
    cmd <= '{sel: 1'b1, write: w, len_ok: ok, target_ro: ro, addr: a, wdata: d, mode: m};
    @(posedge core_clk);
    cmd.sel <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, a, 8'h00, 1'b1, 1'b0);
    chk(reg_rdata === e, "read value");
  endtask
  // Pulse k: 0 confirm, 1 outside cfg write, 2 status clear, 3 frame valid
  task automatic pulse(input int k);
    @(posedge core_clk);
    {wake_frame_valid, bus_wake_status_clear, other_pn_cfg_write, cfg_confirm_set} <= 4'(1 << k);
    @(posedge core_clk);
    {wake_frame_valid, bus_wake_status_clear, other_pn_cfg_write, cfg_confirm_set} <= 4'h0;
    #1;
  endtask
  task automatic t_reset();
    for (int a = 'h26; a <= 'h2e; a++) rd(8'(a), (a == 'h26) ? 8'h05 : 8'h00);
    rd(8'h30, 8'h00);
    chk(bitrate_select_field === RATE_500, "reset rate");
    $display("done reset");
  endtask
  task automatic t_regs();
    logic [7:0] wv [8] = '{8'h11, 8'h22, 8'hcd, 8'hff, 8'h0f, 8'hf0, 8'h3c, 8'hea};
    op(1'b1, 8'h26, 8'hff, 1'b1, 1'b0);
    rd(8'h26, 8'h07);
    foreach (wv[i]) op(1'b1, 8'h27 + 8'(i), wv[i], 1'b1, 1'b0);
    rd(8'h2a, 8'h1f);
    rd(8'h2e, 8'h0a);
    op(1'b1, 8'h30, 8'h55, 1'b1, 1'b0);
    rd(8'h30, 8'h00);
    chk(frame_filter === {1'b1, 29'h1fcd2211, 29'h0a3cf00f}, "ext filter");
    @(posedge core_clk) extended_format_select <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(frame_filter === {1'b0, 29'h7f3, 29'h1ffffa8f}, "std filter");
    @(posedge core_clk) extended_format_select <= 1'b1;
    $display("done regs");
  endtask
  task automatic t_rates();
    for (int c = 0; c < 8; c++) begin
      op(1'b1, 8'h26, 8'(c), 1'b1, 1'b0);
      @(posedge core_clk);
      #1;
      chk(bitrate_select_field === ((c == 4 || c == 6) ? 3'h5 : 3'(c)), "rate");
    end
    $display("done rates");
  endtask
  task automatic t_confirm();
    pulse(0);
    chk(selective_cfg_confirmed === 1'b1, "confirm set");
    op(1'b1, 8'h2b, 8'h00, 1'b1, 1'b0);
    chk(selective_cfg_confirmed === 1'b0, "confirm kept");
    pulse(0);
    pulse(1);
    chk(selective_cfg_confirmed === 1'b0, "confirm kept");
    $display("done confirm");
  endtask
  task automatic t_spi();
    op(1'b1, 8'h27, 8'h11, 1'b1, 1'b0);
    chk(spi_wake === 1'b1 && spi_wake_mode === 3'h2 && cmd_fault_event === 1'b0, "wake");
    op(1'b1, 8'h28, 8'h55, 1'b1, 1'b1);
    chk(cmd_fault_event === 1'b1 && spi_wake === 1'b0, "ro write");
    rd(8'h28, 8'h22);
    op(1'b0, 8'h26, 8'h00, 1'b0, 1'b0);
    chk(cmd_fault_event === 1'b1, "bad length");
    op(1'b1, 8'h27, 8'h11, 1'b1, 1'b0, 3'h5);
    chk(spi_wake === 1'b1 && spi_wake_mode === 3'h5, "wake mode");
    @(posedge core_clk) spi_enabled <= 1'b0;
    op(1'b1, 8'h27, 8'h11, 1'b1, 1'b0);
    chk(spi_wake === 1'b0 && spi_wake_mode === 3'h5, "wake while off");
    @(posedge core_clk) spi_enabled <= 1'b1;
    $display("done spi");
  endtask
  task automatic t_pattern();
    can_bus_node_inst.pattern(10, 2, 10);
    chk(bus_wake_status === 1'b0, "short gap");
    can_bus_node_inst.drive(1'b1, 10);
    can_bus_node_inst.drive(1'b0, 6);
    chk(bus_wake_status === 1'b1 && rxd_force_low === 1'b1, "no wake");
    pulse(2);
    @(posedge core_clk) bus_wake_enable <= 1'b0;
    can_bus_node_inst.pattern(10, 10, 10);
    chk(bus_wake_status === 1'b0, "wake while off");
    @(posedge core_clk) bus_wake_enable <= 1'b1;
    can_bus_node_inst.pattern(10, 250, 10);
    chk(bus_wake_status === 1'b0, "late pattern");
    can_bus_node_inst.drive(1'b1, 10);
    can_bus_node_inst.drive(1'b0, 6);
    chk(bus_wake_status === 1'b1, "no restart");
    pulse(2);
    $display("done pattern");
  endtask
  task automatic t_selective();
    @(posedge core_clk) selective_wake_enable <= 1'b1;
    can_bus_node_inst.pattern(10, 10, 10);
    chk(bus_wake_status === 1'b1 && bias_on === 1'b0, "unconfirmed");
    pulse(2);
    pulse(0);
    can_bus_node_inst.pattern(10, 10, 10);
    chk(bias_on === 1'b1 && bus_wake_status === 1'b0, "no bias");
    pulse(3);
    chk(standby_request === 1'b1, "no standby");
    $display("done selective");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_rates();
    t_confirm();
    t_spi();
    t_pattern();
    t_selective();
    finish_test();
  end
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    fails++;
    $display("ERROR %0t timeout", $time);
    finish_test();
  end
endmodule
